//--- src/gtr_core.v
// Bus command block: terminator, reading relative, remote/local and clears.
// Assumes an external IEEE-488 decoder delivering one-cycle event pulses and the REN line as a level,
// a string parser delivering parsed commands, all synchronous to CLOCK.
`timescale 1ns/1ps

`include "gtr_regs.vh"

module gtr_core #(
  parameter VW = 36
) (
  // Clock and reset
  input  wire          CLOCK,
  input  wire          SYS_RST,
  // Avalon-MM slave
  input  wire [4:0]    AVS_ADDRESS,
  input  wire          AVS_READ,
  input  wire          AVS_WRITE,
  input  wire [31:0]   AVS_WRITEDATA,
  input  wire [3:0]    AVS_BYTEENABLE,
  output reg  [31:0]   AVS_READDATA,
  output reg           AVS_WAITREQUEST,
  // Decoded bus management events
  input  wire          BUS_REN,
  input  wire          BUS_IFC,
  input  wire          BUS_LISTEN_ADDR,
  input  wire          BUS_TALK_ADDR,
  input  wire          BUS_UNLISTEN,
  input  wire          BUS_UNTALK,
  input  wire          BUS_LLO,
  input  wire          BUS_GTL,
  input  wire          BUS_DCL,
  input  wire          BUS_SDC,
  input  wire          BUS_SPE,
  input  wire          BUS_SPD,
  // Parsed device-dependent commands
  input  wire          CMD_VALID,
  input  wire [1:0]    CMD_LETTER,
  input  wire [7:0]    CMD_PARAM,
  input  wire [VW-1:0] CMD_VALUE,
  input  wire          CMD_BAD,
  input  wire          CMD_EXEC,
  output reg           CMD_ERROR,
  // Status byte sources and service request
  input  wire [7:0]    STB_SET,
  output reg           SRQ_REQ,
  // Front panel
  input  wire          KEY_LOCAL,
  input  wire          KEY_OTHER,
  output reg           KEY_ACCEPT,
  output reg           REMOTE_IND,
  output reg           TALK_IND,
  // Readings
  input  wire          RDG_VALID,
  input  wire [VW-1:0] RDG_VALUE,
  input  wire          ONESHOT_MODE,
  input  wire          RDG_TRIGGERED,
  output reg           REL_VALID,
  output reg  [VW-1:0] REL_READING,
  output reg           REL_OVERFLOW,
  output reg           REL_ACTIVE,
  // Output string source
  input  wire          SRC_VALID,
  input  wire [7:0]    SRC_DATA,
  input  wire          SRC_LAST,
  output reg           SRC_READY,
  // Talker byte output
  output reg           TX_VALID,
  output reg  [7:0]    TX_DATA,
  output reg           TX_EOI,
  input  wire          TX_READY
);

  localparam ST_PASS = 2'h0;
  localparam ST_T1   = 2'h1;
  localparam ST_T2   = 2'h2;

  reg  [1:0]    ctrl_r;
  reg  [31:0]   lim_lo_r;
  reg  [31:0]   lim_hi_r;
  reg  [1:0]    term_r,  term_nxt;
  reg           rel_r,   rel_nxt;
  reg           cap_r,   cap_nxt;
  reg  [VW-1:0] ofs_r,   ofs_nxt;
  reg           remote_r, remote_nxt;
  reg           llo_r,   llo_nxt;
  reg           listen_r, listen_nxt;
  reg           talk_r,  talk_nxt;
  reg           spoll_r, spoll_nxt;
  reg           psent_r, psent_nxt;
  reg  [7:0]    stb_r,   stb_nxt;
  reg           py_r,    py_nxt;
  reg  [1:0]    pyv_r,   pyv_nxt;
  reg           pz_r,    pz_nxt;
  reg  [7:0]    pzm_r,   pzm_nxt;
  reg  [VW-1:0] pzv_r,   pzv_nxt;
  reg           pl_r,    pl_nxt;
  reg  [7:0]    plm_r,   plm_nxt;
  reg           bad_r,   bad_nxt;
  reg  [1:0]    st_r,    st_nxt;
  reg           txv_nxt;
  reg  [7:0]    txd_nxt;
  reg           txe_nxt;
  reg           srdy_nxt;
  reg           err_nxt;
  reg           cap_now;
  reg  [VW-1:0] eff_ofs;

  wire          bus_req  = AVS_READ | AVS_WRITE;
  wire          bus_done = bus_req & ~AVS_WAITREQUEST;
  wire [63:0]   ofs_ext  = {{(64-VW){ofs_r[VW-1]}}, ofs_r};
  wire [63:0]   lim_ext  = {lim_hi_r, lim_lo_r};
  wire [63:0]   cval_ext = {{(64-VW){CMD_VALUE[VW-1]}}, CMD_VALUE};
  wire          dev_clr  = BUS_DCL | (BUS_SDC & listen_r);
  wire          src_take = SRC_VALID & SRC_READY;
  wire          tx_free  = ~TX_VALID | TX_READY;
  wire          eoi_en   = ctrl_r[`GTR_CTRL_EOI_BIT];
  wire          rel_pu   = ctrl_r[`GTR_CTRL_RELPU_BIT];

  function [63:0] abs64;
    input [63:0] v;
    begin
      abs64 = v[63] ? (~v + 64'h1) : v;
    end
  endfunction

  function [31:0] bwr;
    input [31:0] old;
    input [31:0] val;
    input [3:0]  be;
    integer      i;
    begin
      bwr = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          bwr[i*8 +: 8] = val[i*8 +: 8];
        end
      end
    end
  endfunction

  // Terminator byte n (0 or 1) for a select code
  function [7:0] term_byte;
    input [1:0] sel;
    input       n;
    begin
      case (sel)
        `GTR_TERM_CRLF: term_byte = n ? `GTR_CHR_LF : `GTR_CHR_CR;
        `GTR_TERM_LFCR: term_byte = n ? `GTR_CHR_CR : `GTR_CHR_LF;
        `GTR_TERM_CR:   term_byte = `GTR_CHR_CR;
        default:        term_byte = `GTR_CHR_LF;
      endcase
    end
  endfunction

  wire [31:0]   ctrl_wr  = bwr({30'h0, ctrl_r}, AVS_WRITEDATA, AVS_BYTEENABLE);

  // Command string buffering, validation and execution
  always @* begin
    py_nxt  = py_r;
    pyv_nxt = pyv_r;
    pz_nxt  = pz_r;
    pzm_nxt = pzm_r;
    pzv_nxt = pzv_r;
    pl_nxt  = pl_r;
    plm_nxt = plm_r;
    bad_nxt = bad_r | CMD_BAD;
    err_nxt = CMD_BAD;
    if (CMD_VALID) begin
      case (CMD_LETTER)
        `GTR_LET_TERM: begin
          if (CMD_PARAM < 8'h04) begin
            py_nxt  = 1'b1;
            pyv_nxt = CMD_PARAM[1:0];
          end else if (CMD_PARAM == `GTR_YPAR_CRLF_ALT) begin
            py_nxt  = 1'b1;
            pyv_nxt = `GTR_TERM_CRLF;
          end else if (CMD_PARAM == `GTR_YPAR_LFCR_ALT) begin
            py_nxt  = 1'b1;
            pyv_nxt = `GTR_TERM_LFCR;
          end else begin
            bad_nxt = 1'b1;
            err_nxt = 1'b1;
          end
        end
        `GTR_LET_REL: begin
          if (CMD_PARAM > `GTR_Z_STORED ||
              (CMD_PARAM == `GTR_Z_VALUE &&
               (abs64(cval_ext) < `GTR_ZVAL_MIN || abs64(cval_ext) > `GTR_ZVAL_MAX))) begin
            bad_nxt = 1'b1;
            err_nxt = 1'b1;
          end else begin
            pz_nxt  = 1'b1;
            pzm_nxt = CMD_PARAM;
            pzv_nxt = CMD_VALUE;
          end
        end
        `GTR_LET_RESTORE: begin
          if (CMD_PARAM == `GTR_L_FACTORY || CMD_PARAM == `GTR_L_SAVED) begin
            pl_nxt  = 1'b1;
            plm_nxt = CMD_PARAM;
          end else begin
            bad_nxt = 1'b1;
            err_nxt = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // Settings, relative state, remote/local and serial poll
  always @* begin
    term_nxt   = term_r;
    rel_nxt    = rel_r;
    cap_nxt    = cap_r;
    ofs_nxt    = ofs_r;
    stb_nxt    = stb_r;
    remote_nxt = remote_r;
    llo_nxt    = llo_r;
    listen_nxt = listen_r;
    talk_nxt   = talk_r;
    spoll_nxt  = spoll_r;
    psent_nxt  = psent_r;
    // Capture waits for a trigger-driven conversion in one-shot mode
    cap_now = cap_r & RDG_VALID & (~ONESHOT_MODE | RDG_TRIGGERED);
    eff_ofs = cap_now ? RDG_VALUE : ofs_r;
    if (cap_now) begin
      ofs_nxt = RDG_VALUE;
      cap_nxt = 1'b0;
    end
    if (CMD_EXEC && !bad_nxt) begin
      if (pl_nxt) begin
        term_nxt = `GTR_TERM_CRLF;
        rel_nxt  = (plm_nxt == `GTR_L_SAVED) ? rel_pu : 1'b0;
        cap_nxt  = 1'b0;
      end
      if (py_nxt) begin
        term_nxt = pyv_nxt;
      end
      if (pz_nxt) begin
        case (pzm_nxt)
          `GTR_Z_OFF: begin
            rel_nxt = 1'b0;
            cap_nxt = 1'b0;
          end
          `GTR_Z_NEXT: begin
            rel_nxt = 1'b1;
            cap_nxt = 1'b1;
          end
          `GTR_Z_VALUE: begin
            rel_nxt = 1'b1;
            cap_nxt = 1'b0;
            ofs_nxt = pzv_nxt;
          end
          default: begin
            rel_nxt = 1'b1;
            cap_nxt = 1'b0;
          end
        endcase
      end
    end
    // Set wins over a clear arriving in the same cycle
    stb_nxt = (dev_clr ? 8'h00 : stb_r) | STB_SET;
    if (dev_clr) begin
      term_nxt = `GTR_TERM_CRLF;
      rel_nxt  = rel_pu;
      cap_nxt  = 1'b0;
    end
    // Addressing
    if (BUS_LISTEN_ADDR) begin
      listen_nxt = 1'b1;
    end else if (BUS_UNLISTEN) begin
      listen_nxt = 1'b0;
    end
    if (BUS_TALK_ADDR) begin
      talk_nxt = 1'b1;
    end else if (BUS_UNTALK) begin
      talk_nxt = 1'b0;
    end
    // Remote and lockout
    if (BUS_LISTEN_ADDR && BUS_REN) begin
      remote_nxt = 1'b1;
    end else if (BUS_GTL && listen_r) begin
      remote_nxt = 1'b0;
      llo_nxt    = 1'b0;
    end else if (KEY_LOCAL && !llo_r) begin
      remote_nxt = 1'b0;
    end
    // Lockout set beats a GTL in the same cycle
    if (BUS_LLO) begin
      llo_nxt = 1'b1;
    end
    if (!BUS_REN) begin
      remote_nxt = 1'b0;
      llo_nxt    = 1'b0;
    end
    // Serial poll
    if (BUS_SPE) begin
      spoll_nxt = 1'b1;
      psent_nxt = 1'b0;
    end else if (BUS_SPD) begin
      spoll_nxt = 1'b0;
    end
    // IFC overrides; status byte is deliberately left alone
    if (BUS_IFC) begin
      remote_nxt = 1'b0;
      listen_nxt = 1'b0;
      talk_nxt   = 1'b0;
      spoll_nxt  = 1'b0;
    end
  end

  // Talker byte path with terminator insertion
  always @* begin
    st_nxt  = st_r;
    txv_nxt = TX_VALID & ~TX_READY;
    txd_nxt = TX_DATA;
    txe_nxt = TX_EOI;
    if (!talk_r) begin
      // Losing talker status abandons the string
      st_nxt  = ST_PASS;
      txv_nxt = 1'b0;
    end else if (st_r == ST_T1 && tx_free) begin
      txv_nxt = 1'b1;
      txd_nxt = term_byte(term_r, 1'b0);
      txe_nxt = eoi_en & term_r[1];
      st_nxt  = term_r[1] ? ST_PASS : ST_T2;
    end else if (st_r == ST_T2 && tx_free) begin
      txv_nxt = 1'b1;
      txd_nxt = term_byte(term_r, 1'b1);
      txe_nxt = eoi_en;
      st_nxt  = ST_PASS;
    end else if (src_take) begin
      txv_nxt = 1'b1;
      txd_nxt = SRC_DATA;
      txe_nxt = 1'b0;
      st_nxt  = SRC_LAST ? ST_T1 : ST_PASS;
    end else if (st_r == ST_PASS && spoll_r && !psent_r && tx_free) begin
      txv_nxt = 1'b1;
      txd_nxt = stb_r;
      txe_nxt = 1'b0;
    end
    srdy_nxt = talk_nxt & ~spoll_nxt & (st_nxt == ST_PASS) & ~txv_nxt & ~src_take;
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      ctrl_r          <= `GTR_CTRL_RST;
      lim_lo_r        <= `GTR_LIM_LO_RST;
      lim_hi_r        <= `GTR_LIM_HI_RST;
      AVS_READDATA    <= 32'h00000000;
      AVS_WAITREQUEST <= 1'b1;
    end else begin
      AVS_WAITREQUEST <= ~(bus_req & AVS_WAITREQUEST);
      if (bus_req && AVS_WAITREQUEST) begin
        case (AVS_ADDRESS)
          `GTR_OFF_CTRL:   AVS_READDATA <= {30'h0, ctrl_r};
          `GTR_OFF_STATUS: AVS_READDATA <= {8'h00, stb_r, 7'h00, spoll_r, talk_r, listen_r,
                                            llo_r, remote_r, cap_r, rel_r, term_r};
          `GTR_OFF_OFS_LO: AVS_READDATA <= ofs_ext[31:0];
          `GTR_OFF_OFS_HI: AVS_READDATA <= ofs_ext[63:32];
          `GTR_OFF_LIM_LO: AVS_READDATA <= lim_lo_r;
          `GTR_OFF_LIM_HI: AVS_READDATA <= lim_hi_r;
          default:         AVS_READDATA <= 32'h00000000;
        endcase
      end
      if (bus_done && AVS_WRITE) begin
        case (AVS_ADDRESS)
          `GTR_OFF_CTRL:   ctrl_r   <= ctrl_wr[1:0];
          `GTR_OFF_LIM_LO: lim_lo_r <= bwr(lim_lo_r, AVS_WRITEDATA, AVS_BYTEENABLE);
          `GTR_OFF_LIM_HI: lim_hi_r <= bwr(lim_hi_r, AVS_WRITEDATA, AVS_BYTEENABLE);
          default: begin
          end
        endcase
      end
    end
  end

  always @(posedge CLOCK) begin
    if (SYS_RST) begin
      term_r       <= `GTR_TERM_CRLF;
      rel_r        <= 1'b0;
      cap_r        <= 1'b0;
      ofs_r        <= {VW{1'b0}};
      remote_r     <= 1'b0;
      llo_r        <= 1'b0;
      listen_r     <= 1'b0;
      talk_r       <= 1'b0;
      spoll_r      <= 1'b0;
      psent_r      <= 1'b0;
      stb_r        <= 8'h00;
      py_r         <= 1'b0;
      pyv_r        <= 2'h0;
      pz_r         <= 1'b0;
      pzm_r        <= 8'h00;
      pzv_r        <= {VW{1'b0}};
      pl_r         <= 1'b0;
      plm_r        <= 8'h00;
      bad_r        <= 1'b0;
      st_r         <= ST_PASS;
      CMD_ERROR    <= 1'b0;
      SRQ_REQ      <= 1'b0;
      KEY_ACCEPT   <= 1'b0;
      REMOTE_IND   <= 1'b0;
      TALK_IND     <= 1'b0;
      REL_VALID    <= 1'b0;
      REL_READING  <= {VW{1'b0}};
      REL_OVERFLOW <= 1'b0;
      REL_ACTIVE   <= 1'b0;
      SRC_READY    <= 1'b0;
      TX_VALID     <= 1'b0;
      TX_DATA      <= 8'h00;
      TX_EOI       <= 1'b0;
    end else begin
      term_r     <= term_nxt;
      rel_r      <= rel_nxt;
      cap_r      <= cap_nxt;
      ofs_r      <= ofs_nxt;
      remote_r   <= remote_nxt;
      llo_r      <= llo_nxt;
      listen_r   <= listen_nxt;
      talk_r     <= talk_nxt;
      spoll_r    <= spoll_nxt;
      psent_r    <= psent_nxt | (txv_nxt & ~TX_VALID & spoll_r & ~src_take & (st_r == ST_PASS));
      stb_r      <= stb_nxt;
      // Buffer empties on execute or on a clear, whatever it held
      if (CMD_EXEC || dev_clr) begin
        py_r  <= 1'b0;
        pz_r  <= 1'b0;
        pl_r  <= 1'b0;
        bad_r <= 1'b0;
      end else begin
        py_r  <= py_nxt;
        pz_r  <= pz_nxt;
        pl_r  <= pl_nxt;
        bad_r <= bad_nxt;
      end
      pyv_r      <= pyv_nxt;
      pzm_r      <= pzm_nxt;
      pzv_r      <= pzv_nxt;
      plm_r      <= plm_nxt;
      st_r       <= st_nxt;
      CMD_ERROR  <= err_nxt;
      SRQ_REQ    <= stb_nxt[`GTR_STB_RQS_BIT];
      KEY_ACCEPT <= KEY_OTHER & ~remote_r & ~llo_r;
      REMOTE_IND <= remote_nxt;
      TALK_IND   <= talk_nxt;
      REL_VALID  <= RDG_VALID;
      REL_ACTIVE <= rel_nxt;
      if (RDG_VALID) begin
        REL_READING  <= rel_r ? (RDG_VALUE - eff_ofs) : RDG_VALUE;
        // Full-scale check on the offset only; the difference and its wrap are not flagged
        REL_OVERFLOW <= rel_r & (abs64({{(64-VW){eff_ofs[VW-1]}}, eff_ofs}) > lim_ext);
      end
      SRC_READY  <= srdy_nxt;
      TX_VALID   <= txv_nxt;
      TX_DATA    <= txd_nxt;
      TX_EOI     <= txe_nxt;
    end
  end

endmodule // gtr_core

//--- src/gtr_regs.vh
// Constants of the bus terminator, relative and remote command block.
// Included by gtr_core.v; definitions only.
`ifndef GTR_REGS_VH
`define GTR_REGS_VH

// Avalon-MM byte offsets
`define GTR_OFF_CTRL      5'h00
`define GTR_OFF_STATUS    5'h04
`define GTR_OFF_OFS_LO    5'h08
`define GTR_OFF_OFS_HI    5'h0C
`define GTR_OFF_LIM_LO    5'h10
`define GTR_OFF_LIM_HI    5'h14

// Control register fields and reset values
`define GTR_CTRL_EOI_BIT  0
`define GTR_CTRL_RELPU_BIT 1
`define GTR_CTRL_RST      2'h1

// Status register fields
`define GTR_ST_TERM_LSB   0
`define GTR_ST_REL_BIT    2
`define GTR_ST_CAP_BIT    3
`define GTR_ST_REM_BIT    4
`define GTR_ST_LLO_BIT    5
`define GTR_ST_LSN_BIT    6
`define GTR_ST_TLK_BIT    7
`define GTR_ST_SPL_BIT    8
`define GTR_ST_STB_LSB    16

// Range limit reset value, nanovolts (30.3 V)
`define GTR_LIM_LO_RST    32'h0E054F00
`define GTR_LIM_HI_RST    32'h00000007

// Programmed offset bounds, nanovolts (1E-9 V to 30.3 V)
`define GTR_ZVAL_MIN      64'h0000000000000001
`define GTR_ZVAL_MAX      64'h000000070E054F00

// Command letters from the string parser
`define GTR_LET_TERM      2'h0
`define GTR_LET_REL       2'h1
`define GTR_LET_RESTORE   2'h2
`define GTR_LET_OTHER     2'h3

// Terminator select codes
`define GTR_TERM_CRLF     2'h0
`define GTR_TERM_LFCR     2'h1
`define GTR_TERM_CR       2'h2
`define GTR_TERM_LF       2'h3
`define GTR_YPAR_CRLF_ALT 8'h0A
`define GTR_YPAR_LFCR_ALT 8'h0D

// Relative modes and restore commands
`define GTR_Z_OFF         8'h00
`define GTR_Z_NEXT        8'h01
`define GTR_Z_VALUE       8'h02
`define GTR_Z_STORED      8'h03
`define GTR_L_FACTORY     8'h01
`define GTR_L_SAVED       8'h02

// Terminator characters
`define GTR_CHR_CR        8'h0D
`define GTR_CHR_LF        8'h0A

// Status byte request-service bit
`define GTR_STB_RQS_BIT   6

`endif

//--- tb/gtr_core_bench.sv
// Self-checking bench for gtr_core: registers, commands, readings, bus events.
// Controller stand-in is gtr_ctl_model; assertions arrive through the bind.
`timescale 1ns/1ps
`include "gtr_regs.vh"

module gtr_core_bench;
  `define CHK(g, x) begin samples_checked++; if ((g) !== (x)) begin err_total++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, g, x); end end
  localparam int LSN = 0, TLK = 1, UNT = 3, LLO = 4, GTL = 5, DCL = 6, SDC = 7, SPE = 8, SPD = 9;
  logic        CLOCK = '0, SYS_RST = '1, AVS_READ = '0, AVS_WRITE = '0, CMD_VALID = '0;
  logic        CMD_BAD = '0, CMD_EXEC = '0, KEY_LOCAL = '0, KEY_OTHER = '0, RDG_VALID = '0;
  logic        ONESHOT_MODE = '0, RDG_TRIGGERED = '0, SRC_VALID = '0, SRC_LAST = '1;
  logic [4:0]  AVS_ADDRESS = '0;
  logic [31:0] AVS_WRITEDATA = '0, AVS_READDATA, q;
  logic [3:0]  AVS_BYTEENABLE = 4'hF;
  logic [1:0]  CMD_LETTER = '0;
  logic [7:0]  CMD_PARAM = '0, STB_SET = '0, SRC_DATA = 8'h41, TX_DATA;
  logic [35:0] CMD_VALUE = '0, RDG_VALUE = '0, REL_READING;
  logic        AVS_WAITREQUEST, CMD_ERROR, SRQ_REQ, KEY_ACCEPT, REMOTE_IND, TALK_IND, e;
  logic        REL_VALID, REL_OVERFLOW, REL_ACTIVE, SRC_READY, TX_VALID, TX_EOI, TX_READY;
  logic        BUS_REN, BUS_IFC, BUS_LISTEN_ADDR, BUS_TALK_ADDR, BUS_UNLISTEN, BUS_UNTALK;
  logic        BUS_LLO, BUS_GTL, BUS_DCL, BUS_SDC, BUS_SPE, BUS_SPD;
  logic [7:0]  yp[6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h0A, 8'h0D};
  logic [1:0]  yc[6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h0, 2'h1};
  int          err_total = 0, samples_checked = 0;

  gtr_core #(.VW(36)) i_dut (.*);
  gtr_ctl_model i_ctl (.*);

  initial begin
    forever #25 CLOCK = ~CLOCK;
  end

  task tick(input int n);
    repeat (n) @(posedge CLOCK);
  endtask

  task close_out();
    $display("Comparisons %0d, mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task lim(input int n);
    if (n >= 20) begin
      err_total++;
      close_out();
    end
  endtask

  task automatic av(input bit wr, input logic [4:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge CLOCK);
    AVS_ADDRESS <= a;
    AVS_WRITEDATA <= d;
    AVS_READ <= !wr;
    AVS_WRITE <= wr;
    do begin
      @(posedge CLOCK);
      n++;
    end while (AVS_WAITREQUEST !== 1'h0 && n < 20);
    q = AVS_READDATA;
    AVS_READ <= '0;
    AVS_WRITE <= '0;
    lim(n);
  endtask

  task rd(input logic [4:0] a, input logic [31:0] x);
    av(0, a, 32'h0);
    `CHK(q, x)
  endtask

  task cmd(input logic [1:0] l, input logic [7:0] p, input logic [35:0] v, input bit x);
    @(posedge CLOCK);
    CMD_VALID <= '1;
    CMD_LETTER <= l;
    CMD_PARAM <= p;
    CMD_VALUE <= v;
    @(posedge CLOCK);
    CMD_VALID <= '0;
    CMD_EXEC <= x;
    @(posedge CLOCK);
    e = CMD_ERROR;
    CMD_EXEC <= '0;
  endtask

  task rdg(input logic [35:0] v, input bit t, input logic [35:0] x);
    @(posedge CLOCK);
    RDG_VALID <= '1;
    RDG_VALUE <= v;
    RDG_TRIGGERED <= t;
    @(posedge CLOCK);
    RDG_VALID <= '0;
    @(posedge CLOCK);
    `CHK(REL_VALID, 1'h1)
    `CHK(REL_READING, x)
  endtask

  task key(input bit loc, input logic acc, input logic remote_indicator);
    @(posedge CLOCK);
    KEY_LOCAL <= loc;
    KEY_OTHER <= !loc;
    @(posedge CLOCK);
    KEY_LOCAL <= '0;
    KEY_OTHER <= '0;
    @(posedge CLOCK);
    `CHK(KEY_ACCEPT, acc)
    `CHK(REMOTE_IND, remote_indicator)
  endtask

  // One data byte, then the terminator bytes the code calls for
  task automatic talk(input logic [1:0] c, input bit eoi);
    logic [8:0] x[$];
    int n = 0;
    x.push_back(9'h041);
    x.push_back({c[1] & eoi, c[0] ? 8'h0A : 8'h0D});
    if (!c[1])
      x.push_back({eoi, c[0] ? 8'h0D : 8'h0A});
    i_ctl.rx_q.delete();
    i_ctl.ev(TLK);
    @(posedge CLOCK);
    SRC_VALID <= '1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (SRC_READY !== 1'h1 && n < 20);
    SRC_VALID <= '0;
    lim(n);
    tick(20);
    i_ctl.ev(UNT);
    `CHK(i_ctl.rx_q.size(), x.size())
    foreach (x[i]) `CHK(i_ctl.rx_q[i], x[i])
  endtask

  initial begin
    tick(5);
    SYS_RST <= '0;
    rd(`GTR_OFF_CTRL, 32'h1);
    rd(`GTR_OFF_STATUS, 32'h0);
    rd(`GTR_OFF_LIM_LO, `GTR_LIM_LO_RST);
    rd(`GTR_OFF_LIM_HI, `GTR_LIM_HI_RST);
    rd(5'h18, 32'h0);
    av(1, `GTR_OFF_STATUS, 32'hFF);
    rd(`GTR_OFF_STATUS, 32'h0);
    $display("Register test done");
    foreach (yp[i]) begin
      cmd(`GTR_LET_TERM, yp[i], 36'h0, 1);
      i_ctl.slow <= i[0];
      rd(`GTR_OFF_STATUS, {30'h0, yc[i]});
      talk(yc[i], 1'h1);
    end
    av(1, `GTR_OFF_CTRL, 32'h0);
    talk(2'h1, 1'h0);
    av(1, `GTR_OFF_CTRL, 32'h1);
    $display("Terminator test done");
    cmd(`GTR_LET_TERM, 8'h02, 36'h0, 0);
    rd(`GTR_OFF_STATUS, 32'h1);
    cmd(`GTR_LET_TERM, 8'h04, 36'h0, 1);
    `CHK(e, 1'h1)
    rd(`GTR_OFF_STATUS, 32'h1);
    cmd(`GTR_LET_REL, 8'h04, 36'h0, 1);
    `CHK(e, 1'h1)
    cmd(`GTR_LET_REL, 8'h02, 36'h0, 1);
    `CHK(e, 1'h1)
    cmd(`GTR_LET_REL, 8'h02, 36'h70E054F01, 1);
    `CHK(e, 1'h1)
    cmd(`GTR_LET_TERM, 8'h02, 36'h0, 0);
    cmd(`GTR_LET_OTHER, 8'h00, 36'h0, 1);
    rd(`GTR_OFF_STATUS, 32'h2);
    cmd(`GTR_LET_RESTORE, 8'h01, 36'h0, 1);
    rd(`GTR_OFF_STATUS, 32'h0);
    cmd(`GTR_LET_TERM, 8'h03, 36'h0, 1);
    cmd(`GTR_LET_RESTORE, 8'h02, 36'h0, 1);
    rd(`GTR_OFF_STATUS, 32'h0);
    CMD_BAD <= '1;
    tick(1);
    CMD_BAD <= '0;
    cmd(`GTR_LET_TERM, 8'h02, 36'h0, 1);
    rd(`GTR_OFF_STATUS, 32'h0);
    $display("Command test done");
    cmd(`GTR_LET_REL, 8'h01, 36'h0, 1);
    rdg(36'h1F4, 1, 36'h0);
    rdg(36'h2BC, 1, 36'hC8);
    cmd(`GTR_LET_REL, 8'h02, 36'h3E8, 1);
    rdg(36'h5DC, 1, 36'h1F4);
    rd(`GTR_OFF_OFS_LO, 32'h3E8);
    cmd(`GTR_LET_REL, 8'h00, 36'h0, 1);
    rdg(36'h5DC, 1, 36'h5DC);
    cmd(`GTR_LET_REL, 8'h03, 36'h0, 1);
    rdg(36'h4B0, 1, 36'hC8);
    ONESHOT_MODE <= '1;
    cmd(`GTR_LET_REL, 8'h01, 36'h0, 1);
    rdg(36'h384, 0, 36'hFFFFFFF9C);
    rdg(36'h384, 1, 36'h0);
    ONESHOT_MODE <= '0;
    av(1, `GTR_OFF_LIM_LO, 32'h64);
    av(1, `GTR_OFF_LIM_HI, 32'h0);
    cmd(`GTR_LET_REL, 8'h02, 36'h3E8, 1);
    rdg(36'h5DC, 1, 36'h1F4);
    `CHK(REL_OVERFLOW, 1'h1)
    av(1, `GTR_OFF_LIM_LO, `GTR_LIM_LO_RST);
    av(1, `GTR_OFF_LIM_HI, `GTR_LIM_HI_RST);
    rdg(36'h5DC, 1, 36'h1F4);
    `CHK(REL_OVERFLOW, 1'h0)
    $display("Relative test done");
    @(posedge CLOCK);
    STB_SET <= 8'h41;
    @(posedge CLOCK);
    STB_SET <= 8'h00;
    tick(2);
    `CHK(SRQ_REQ, 1'h1)
    i_ctl.rx_q.delete();
    i_ctl.ev(SPE);
    i_ctl.ev(TLK);
    tick(10);
    `CHK(i_ctl.rx_q.size(), 1)
    `CHK(i_ctl.rx_q[0], 9'h041)
    i_ctl.ev(SPD);
    i_ctl.ev(UNT);
    i_ctl.ifc();
    tick(1);
    `CHK(SRQ_REQ, 1'h1)
    av(1, `GTR_OFF_CTRL, 32'h3);
    cmd(`GTR_LET_TERM, 8'h03, 36'h0, 1);
    i_ctl.ev(DCL);
    tick(2);
    `CHK(SRQ_REQ, 1'h0)
    `CHK(REL_ACTIVE, 1'h1)
    rd(`GTR_OFF_STATUS, 32'h4);
    av(1, `GTR_OFF_CTRL, 32'h1);
    $display("Poll and clear test done");
    i_ctl.ren(1);
    tick(3);
    `CHK(REMOTE_IND, 1'h0)
    i_ctl.ev(LSN);
    tick(1);
    `CHK(REMOTE_IND, 1'h1)
    key(0, 1'h0, 1'h1);
    key(1, 1'h0, 1'h0);
    key(0, 1'h1, 1'h0);
    i_ctl.ev(LSN);
    i_ctl.ev(LLO);
    key(1, 1'h0, 1'h1);
    i_ctl.ev(GTL);
    tick(1);
    `CHK(REMOTE_IND, 1'h0)
    key(0, 1'h1, 1'h0);
    i_ctl.ev(LSN);
    cmd(`GTR_LET_TERM, 8'h02, 36'h0, 1);
    i_ctl.ev(SDC);
    rd(`GTR_OFF_STATUS, 32'h50);
    i_ctl.ev(TLK);
    tick(1);
    `CHK(TALK_IND, 1'h1)
    i_ctl.ifc();
    tick(1);
    `CHK(REMOTE_IND, 1'h0)
    `CHK(TALK_IND, 1'h0)
    rd(`GTR_OFF_STATUS, 32'h0);
    $display("Remote test done");
    close_out();
  end
endmodule // gtr_core_bench

//--- tb/gtr_core_checker.sv
// Concurrent checks on the terminator, relative and remote command block.
// Bound to gtr_core; sees its ports only, one clock, synchronous reset.
`timescale 1ns/1ps
`include "gtr_regs.vh"

module gtr_core_checker #(
  parameter VW = 36
) (
  // Clock and reset
  input logic          CLOCK,
  input logic          SYS_RST,
  // Register bus
  input logic          AVS_READ,
  input logic          AVS_WRITE,
  input logic          AVS_WAITREQUEST,
  // Bus events
  input logic          BUS_REN,
  input logic          BUS_IFC,
  input logic          BUS_LISTEN_ADDR,
  // Commands
  input logic          CMD_VALID,
  input logic [1:0]    CMD_LETTER,
  input logic [7:0]    CMD_PARAM,
  input logic          CMD_BAD,
  input logic          CMD_EXEC,
  input logic          CMD_ERROR,
  // Front panel
  input logic          KEY_OTHER,
  input logic          KEY_ACCEPT,
  input logic          REMOTE_IND,
  input logic          TALK_IND,
  // Readings
  input logic          RDG_VALID,
  input logic          ONESHOT_MODE,
  input logic [VW-1:0] REL_READING,
  // Talker
  input logic          TX_VALID,
  input logic [7:0]    TX_DATA,
  input logic          TX_EOI,
  input logic          TX_READY
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  sequence bus_done;
    $fell(AVS_WAITREQUEST) ##1 AVS_WAITREQUEST;
  endsequence
  sequence z1_exec;
    CMD_VALID && !CMD_BAD && CMD_LETTER == `GTR_LET_REL && CMD_PARAM == `GTR_Z_NEXT
      ##1 CMD_EXEC && !CMD_BAD;
  endsequence

  wait_one_a: assert property ((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> bus_done)
    else $error("bus request not answered after one wait state");
  bad_param_a: assert property (CMD_VALID && (CMD_LETTER == `GTR_LET_REL && CMD_PARAM > 8'h03
    || CMD_LETTER == `GTR_LET_TERM && CMD_PARAM > 8'h03 && CMD_PARAM != 8'h0A
    && CMD_PARAM != 8'h0D) |=> CMD_ERROR) else $error("bad parameter not flagged");
  good_param_a: assert property (CMD_VALID && !CMD_BAD && CMD_LETTER == `GTR_LET_TERM
    && (CMD_PARAM <= 8'h03 || CMD_PARAM == 8'h0A || CMD_PARAM == 8'h0D) |=> !CMD_ERROR)
    else $error("valid terminator select flagged");
  eoi_term_a: assert property (TX_VALID && TX_EOI |-> TX_DATA == 8'h0D || TX_DATA == 8'h0A)
    else $error("end marker not on a terminator byte");
  tx_hold_a: assert property (TX_VALID && !TX_READY |=> !TX_VALID || $stable(TX_DATA))
    else $error("output byte changed while stalled");
  ifc_idle_a: assert property (BUS_IFC |=> !REMOTE_IND && !TALK_IND)
    else $error("interface clear left remote or talker");
  remote_cause_a: assert property ($rose(REMOTE_IND) |-> $past(BUS_LISTEN_ADDR && BUS_REN))
    else $error("remote without listen address and enable");
  key_block_a: assert property (KEY_OTHER && REMOTE_IND |=> !KEY_ACCEPT)
    else $error("panel key accepted while remote");
  rel_capture_a: assert property (z1_exec ##[1:3] RDG_VALID && !ONESHOT_MODE
    |=> REL_READING == '0) else $error("captured reading not zero");
endmodule // gtr_core_checker

bind gtr_core gtr_core_checker #(.VW(VW)) i_chk (.*);

//--- tb/gtr_ctl_model.sv
// Bus controller stand-in: management events, interface clear, talker bytes.
// Drives the decoded event inputs of gtr_core; accepted bytes land in rx_q.
`timescale 1ns/1ps

module gtr_ctl_model (
  // Clock
  input  logic       CLOCK,
  // Management lines and events
  output logic       BUS_REN,
  output logic       BUS_IFC,
  output logic       BUS_LISTEN_ADDR,
  output logic       BUS_TALK_ADDR,
  output logic       BUS_UNLISTEN,
  output logic       BUS_UNTALK,
  output logic       BUS_LLO,
  output logic       BUS_GTL,
  output logic       BUS_DCL,
  output logic       BUS_SDC,
  output logic       BUS_SPE,
  output logic       BUS_SPD,
  // Talker handshake
  input  logic       TX_VALID,
  input  logic [7:0] TX_DATA,
  input  logic       TX_EOI,
  output logic       TX_READY
);
  logic [9:0] ev_r = '0;
  logic       slow = '0;
  logic [8:0] rx_q[$];

  assign {BUS_SPD, BUS_SPE, BUS_SDC, BUS_DCL, BUS_GTL, BUS_LLO, BUS_UNTALK, BUS_UNLISTEN,
          BUS_TALK_ADDR, BUS_LISTEN_ADDR} = ev_r;

  initial begin
    BUS_REN = '0;
    BUS_IFC = '0;
    TX_READY = '0;
  end

  // Slow mode drops ready on every other cycle to exercise the hold
  always @(posedge CLOCK) begin
    TX_READY <= !slow || !TX_READY;
    if (TX_VALID && TX_READY)
      rx_q.push_back({TX_EOI, TX_DATA});
  end

  task ev(input int k);
    @(posedge CLOCK);
    ev_r <= 10'h001 << k;
    @(posedge CLOCK);
    ev_r <= '0;
  endtask

  task ren(input logic v);
    @(posedge CLOCK);
    BUS_REN <= v;
  endtask

  task ifc();
    @(posedge CLOCK);
    BUS_IFC <= '1;
    repeat (2000) @(posedge CLOCK);
    BUS_IFC <= '0;
  endtask
endmodule // gtr_ctl_model
